// ### hw/sgbd_osc_ready.sv
// Purpose: Ready flag of one low-speed oscillator.
// Assumes: osc_clk is a slow oscillator sampled as a synchronous input.
// Notes:   The flag falls OFF_CYC oscillator edges after the enable drops.
`timescale 1ns/100ps
module sgbd_osc_ready #(
  parameter int unsigned OFF_CYC = 6
) (
  input  wire logic aclk,       // System clock.
  input  wire logic rst_n,      // Synchronous reset, active low.
  input  wire logic osc_en,     // Oscillator enable from software.
  input  wire logic osc_stable, // Oscillator reports stable output.
  input  wire logic osc_clk,    // Sampled oscillator clock.
  output logic      ready       // Oscillator ready flag.
);
  localparam int unsigned CW = $clog2(OFF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(OFF_CYC - 1);

  logic          osc_q_r;
  logic [CW-1:0] cnt_r;
  logic          osc_edge;

  assign osc_edge = osc_clk && !osc_q_r;

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      osc_q_r <= 1'b0;
    end else begin
      osc_q_r <= osc_clk;
    end
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      ready <= 1'b0;
      cnt_r <= '0;
    end else if (osc_en) begin
      ready <= osc_stable; // R11
      cnt_r <= '0;
    end else if (ready && osc_edge) begin
      if (cnt_r == LAST) begin
        ready <= 1'b0; // R12 R19
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  ready_fall_a: assert property (@(posedge aclk) disable iff (!rst_n) // R12
    ready && !osc_en && osc_edge && cnt_r == LAST |=> !ready)
    else $error("ready flag did not fall after the last edge");

  ready_hold_a: assert property (@(posedge aclk) disable iff (!rst_n) // R19
    ready && !osc_en && !(osc_edge && cnt_r == LAST) |=> ready)
    else $error("ready flag fell too early");
endmodule

// ### hw/sgbd_pkg.sv
// Purpose: Shared constants and types for the sleep gating and backup
//          domain controller.
// Assumes: One system clock; registers on a 32-bit AXI4-Lite slave.
// Notes:   Register offsets are byte addresses.
package sgbd_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned PERIPH_W = 19;

  localparam logic [7:0] OFF_SLEEP = 8'h64;
  localparam logic [7:0] OFF_BDC   = 8'h70;
  localparam logic [7:0] OFF_CSR   = 8'h74;

  localparam logic [31:0] SLEEP_RST  = 32'h0007_7930;
  localparam logic [31:0] SLEEP_IMPL = 32'h0007_7931;
  localparam logic [31:0] CSR_RST    = 32'h0E00_0000;

  localparam int unsigned BD_SLOW_EXT_OSC_ENABLE  = 0;
  localparam int unsigned BD_SLOW_EXT_OSC_READY = 1;
  localparam int unsigned BD_SLOW_EXT_OSC_BYPASS = 2;
  localparam int unsigned BD_SEL_LO = 8;
  localparam int unsigned BD_RTC_CLOCK_GATE  = 15;
  localparam int unsigned BD_BACKUP_DOMAIN_SOFT_RESET  = 16;

  localparam int unsigned CS_SLOW_INT_OSC_ENABLE   = 0;
  localparam int unsigned CS_SLOW_INT_OSC_READY  = 1;
  localparam int unsigned CS_RESET_FLAG_REMOVAL    = 24;
  localparam int unsigned CS_FLAG_LO = 25;
  localparam int unsigned FLAG_W     = 7;
  localparam int unsigned FLAG_LPWR  = 6;
  localparam int unsigned FLAG_WWDG  = 5;
  localparam logic [6:0]  FLAG_RST   = 7'h07;

  localparam int unsigned LSE_OFF_CYC = 6;
  localparam int unsigned LSI_OFF_CYC = 3;
  localparam logic [1:0]  BKP_WAIT    = 2'h3;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_ERR    = 2'h2;

  typedef enum logic [1:0] {
    RTC_NONE = 2'h0,
    RTC_LSE  = 2'h1,
    RTC_LSI  = 2'h2,
    RTC_HSE  = 2'h3
  } sgbd_rtc_src_t;

  typedef enum logic [1:0] {
    SEL_NONE  = 2'h0,
    SEL_SLEEP = 2'h1,
    SEL_BDC   = 2'h2,
    SEL_CSR   = 2'h3
  } sgbd_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_RESP = 3'h4
  } sgbd_bus_t;
endpackage

// ### hw/sgbd_top.sv
// Purpose: Sleep clock gating and backup domain control registers.
// Assumes: Reset, backup reset and power reset inputs are synchronous.
// Notes:   Oscillator clocks are sampled inputs; rtc_clk is a mux.
// Contract
// [R1] Sleep enable 1 keeps a second-bus peripheral clock in Sleep mode.
// [R2] Sleep enable register resets to 0x00077930; reserved bits read reset.
// [R3] Sleep enable register takes byte, half and word writes, no wait.
// [R4] Backup control bits stay locked until the write unlock is set; soft reset bit 16 is written without the unlock.
// [R5] Backup bits clear only on backup domain reset, not system reset.
// [R6] Soft reset bit 16 holds the whole backup domain in reset.
// [R7] RTC gate bit 15 passes the RTC clock when 1.
// [R8] Source select: none, slow external, slow internal, fast divided.
// [R9] Once a source is chosen, select is frozen until backup reset.
// [R10] Bypass bit 2 writes only while slow external oscillator is off.
// [R11] Slow external ready flag follows oscillator stability.
// [R12] Ready falls six oscillator cycles after the enable clears.
// [R13] Enable bit 0 switches the slow external oscillator on and off.
// [R14] Backup and status registers add up to 3 waits when successive.
// [R15] Status register resets to 0x0E000000; flags only on power reset.
// [R16] Low-power reset flag bit 31 sets on event, clears on removal.
// [R17] Watchdog reset flag bit 30 sets on event, clears on removal.
// [R18] Writing 1 to bit 24 clears every reset flag; 0 does nothing.
// [R19] Internal ready falls three oscillator cycles after enable clears.
// [R20] Converter sleep enable acts like the others.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
module sgbd_top #(
  parameter logic [1:0] WAIT_CYC = sgbd_pkg::BKP_WAIT
) (
  input  wire logic                        aclk,          // System clock.
  input  wire logic                        aresetn,       // System reset.
  input  wire logic                        bkp_rst_n,     // Backup reset.
  input  wire logic                        por_n,         // Power reset.
  input  wire logic [sgbd_pkg::ADDR_W-1:0] s_axi_awaddr,  // Write address.
  input  wire logic                        s_axi_awvalid, // Address valid.
  output logic                             s_axi_awready, // Address ready.
  input  wire logic [31:0]                 s_axi_wdata,   // Write data.
  input  wire logic [3:0]                  s_axi_wstrb,   // Byte strobes.
  input  wire logic                        s_axi_wvalid,  // Data valid.
  output logic                             s_axi_wready,  // Data ready.
  output logic [1:0]                       s_axi_bresp,   // Write resp.
  output logic                             s_axi_bvalid,  // Resp valid.
  input  wire logic                        s_axi_bready,  // Resp ready.
  input  wire logic [sgbd_pkg::ADDR_W-1:0] s_axi_araddr,  // Read address.
  input  wire logic                        s_axi_arvalid, // Address valid.
  output logic                             s_axi_arready, // Address ready.
  output logic [31:0]                      s_axi_rdata,   // Read data.
  output logic [1:0]                       s_axi_rresp,   // Read resp.
  output logic                             s_axi_rvalid,  // Data valid.
  input  wire logic                        s_axi_rready,  // Data ready.
  input  wire logic                        sleep_mode,    // Core sleeps.
  input  wire logic                        backup_write_unlock, // Unlock.
  input  wire logic [sgbd_pkg::FLAG_W-1:0] rst_cause_evt, // Cause pulses.
  input  wire logic                        slow_ext_osc_stable, // Stable.
  input  wire logic                        slow_ext_osc_clk,    // Clock.
  input  wire logic                        slow_int_osc_stable, // Stable.
  input  wire logic                        slow_int_osc_clk,    // Clock.
  input  wire logic                        fast_ext_div_clk,    // Divided.
  output logic [sgbd_pkg::PERIPH_W-1:0]    periph_clk_run, // Clock runs.
  output logic                             slow_ext_osc_enable, // SLOW_EXTERNAL_OSCILLATOR on.
  output logic                             slow_ext_osc_bypass, // Bypass.
  output logic                             slow_int_osc_enable, // SLOW_INTERNAL_OSCILLATOR on.
  output logic [1:0]                       rtc_source_select,   // Source.
  output logic                             rtc_clk,       // RTC clock.
  output logic                             bkp_domain_rst // Domain reset.
);
  ////////////////////////////////////////////////////////////////////////
  function automatic sgbd_pkg::sgbd_sel_t dec(
    input logic [sgbd_pkg::ADDR_W-1:0] a
  );
    if (a == sgbd_pkg::OFF_SLEEP) begin
      dec = sgbd_pkg::SEL_SLEEP;
    end else if (a == sgbd_pkg::OFF_BDC) begin
      dec = sgbd_pkg::SEL_BDC;
    end else if (a == sgbd_pkg::OFF_CSR) begin
      dec = sgbd_pkg::SEL_CSR;
    end else begin
      dec = sgbd_pkg::SEL_NONE;
    end
  endfunction

  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    merge = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[8*b +: 8] = new_v[8*b +: 8];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  sgbd_pkg::sgbd_bus_t         wst_r;
  sgbd_pkg::sgbd_bus_t         rst_r;
  logic                        aw_have_r;
  logic                        w_have_r;
  logic [sgbd_pkg::ADDR_W-1:0] awaddr_r;
  logic [sgbd_pkg::ADDR_W-1:0] araddr_r;
  logic [31:0]                 wdata_r;
  logic [3:0]                  wstrb_r;
  logic [1:0]                  wcnt_r;
  logic [1:0]                  rcnt_r;
  logic                        bkp_last_r;
  sgbd_pkg::sgbd_sel_t         wsel;
  sgbd_pkg::sgbd_sel_t         rsel;
  logic                        wr_do;
  logic                        rd_do;
  logic                        w_bkp;
  logic                        r_bkp;
  logic [31:0]                 sleep_r;
  logic                        slow_ext_osc_enable_r;
  logic                        slow_ext_osc_bypass_r;
  logic [1:0]                  rtc_source_select_r;
  logic                        rtc_clock_gate_r;
  logic                        backup_domain_soft_reset_r;
  logic                        slow_int_osc_enable_r;
  logic [sgbd_pkg::FLAG_W-1:0] flags_r;
  logic                        lse_rdy;
  logic                        lsi_rdy;
  logic [31:0]                 bdc_img;
  logic [31:0]                 csr_img;
  logic [31:0]                 rd_img;
  logic [31:0]                 wd;
  logic                        wr_sleep;
  logic                        wr_bdc;
  logic                        wr_csr;
  logic                        rmv;

  assign wsel  = dec(awaddr_r);
  assign rsel  = dec(araddr_r);
  assign w_bkp = wsel == sgbd_pkg::SEL_BDC || wsel == sgbd_pkg::SEL_CSR;
  assign r_bkp = rsel == sgbd_pkg::SEL_BDC || rsel == sgbd_pkg::SEL_CSR;
  assign wr_do = wst_r == sgbd_pkg::ST_WAIT && wcnt_r == '0;
  assign rd_do = rst_r == sgbd_pkg::ST_WAIT && rcnt_r == '0;

  assign s_axi_awready = wst_r == sgbd_pkg::ST_IDLE && !aw_have_r;
  assign s_axi_wready  = wst_r == sgbd_pkg::ST_IDLE && !w_have_r;
  assign s_axi_bvalid  = wst_r == sgbd_pkg::ST_RESP;
  assign s_axi_arready = rst_r == sgbd_pkg::ST_IDLE;
  assign s_axi_rvalid  = rst_r == sgbd_pkg::ST_RESP;

  ////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are caught in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r       <= sgbd_pkg::ST_IDLE;
      aw_have_r   <= 1'b0;
      w_have_r    <= 1'b0;
      awaddr_r    <= '0;
      wdata_r     <= '0;
      wstrb_r     <= '0;
      wcnt_r      <= '0;
      s_axi_bresp <= sgbd_pkg::RESP_OK;
    end else begin
      unique case (wst_r)
        sgbd_pkg::ST_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
          end
          if (aw_have_r && w_have_r) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            wst_r     <= sgbd_pkg::ST_WAIT;
            wcnt_r    <= (w_bkp && bkp_last_r) ? WAIT_CYC : '0; // R3 R14
          end
        end
        sgbd_pkg::ST_WAIT: begin
          if (wcnt_r == '0) begin
            wst_r       <= sgbd_pkg::ST_RESP;
            s_axi_bresp <= (wsel == sgbd_pkg::SEL_NONE) ?
                           sgbd_pkg::RESP_ERR : sgbd_pkg::RESP_OK;
          end else begin
            wcnt_r <= wcnt_r - 1'b1;
          end
        end
        sgbd_pkg::ST_RESP: begin
          if (s_axi_bready) begin
            wst_r <= sgbd_pkg::ST_IDLE;
          end
        end
        default: begin
          wst_r <= sgbd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r       <= sgbd_pkg::ST_IDLE;
      araddr_r    <= '0;
      rcnt_r      <= '0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sgbd_pkg::RESP_OK;
    end else begin
      unique case (rst_r)
        sgbd_pkg::ST_IDLE: begin
          if (s_axi_arvalid) begin
            araddr_r <= s_axi_araddr;
            rst_r    <= sgbd_pkg::ST_WAIT;
            rcnt_r   <= (dec(s_axi_araddr) == sgbd_pkg::SEL_BDC ||
                         dec(s_axi_araddr) == sgbd_pkg::SEL_CSR) &&
                        bkp_last_r ? WAIT_CYC : '0; // R14
          end
        end
        sgbd_pkg::ST_WAIT: begin
          if (rcnt_r == '0) begin
            rst_r       <= sgbd_pkg::ST_RESP;
            s_axi_rdata <= rd_img;
            s_axi_rresp <= (rsel == sgbd_pkg::SEL_NONE) ?
                           sgbd_pkg::RESP_ERR : sgbd_pkg::RESP_OK;
          end else begin
            rcnt_r <= rcnt_r - 1'b1;
          end
        end
        sgbd_pkg::ST_RESP: begin
          if (s_axi_rready) begin
            rst_r <= sgbd_pkg::ST_IDLE;
          end
        end
        default: begin
          rst_r <= sgbd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Remembers whether the last finished access hit a backup register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bkp_last_r <= 1'b0;
    end else if (wr_do || rd_do) begin
      bkp_last_r <= (wr_do && w_bkp) || (rd_do && r_bkp); // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    bdc_img = '0;
    bdc_img[sgbd_pkg::BD_SLOW_EXT_OSC_ENABLE]       = slow_ext_osc_enable_r;
    bdc_img[sgbd_pkg::BD_SLOW_EXT_OSC_READY]      = lse_rdy;
    bdc_img[sgbd_pkg::BD_SLOW_EXT_OSC_BYPASS]      = slow_ext_osc_bypass_r;
    bdc_img[sgbd_pkg::BD_SEL_LO +: 2] = rtc_source_select_r;
    bdc_img[sgbd_pkg::BD_RTC_CLOCK_GATE]       = rtc_clock_gate_r;
    bdc_img[sgbd_pkg::BD_BACKUP_DOMAIN_SOFT_RESET]       = backup_domain_soft_reset_r;
    csr_img = '0;
    csr_img[sgbd_pkg::CS_SLOW_INT_OSC_ENABLE]  = slow_int_osc_enable_r;
    csr_img[sgbd_pkg::CS_SLOW_INT_OSC_READY] = lsi_rdy;
    csr_img[sgbd_pkg::CS_FLAG_LO +: sgbd_pkg::FLAG_W] = flags_r;
  end

  always_comb begin
    unique case (rsel)
      sgbd_pkg::SEL_SLEEP: rd_img = sleep_r;
      sgbd_pkg::SEL_BDC:   rd_img = bdc_img;
      sgbd_pkg::SEL_CSR:   rd_img = csr_img;
      sgbd_pkg::SEL_NONE:  rd_img = '0;
    endcase
  end

  assign wr_sleep = wr_do && wsel == sgbd_pkg::SEL_SLEEP;
  assign wr_bdc   = wr_do && wsel == sgbd_pkg::SEL_BDC;
  assign wr_csr   = wr_do && wsel == sgbd_pkg::SEL_CSR;
  assign wd = merge(wsel == sgbd_pkg::SEL_BDC ? bdc_img :
                    wsel == sgbd_pkg::SEL_CSR ? csr_img : sleep_r,
                    wdata_r, wstrb_r); // R3 R14
  assign rmv = wr_csr && wd[sgbd_pkg::CS_RESET_FLAG_REMOVAL]; // R18

  // Sleep enables; unimplemented bits stay at their reset value of zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sleep_r <= sgbd_pkg::SLEEP_RST; // R2
    end else if (wr_sleep) begin
      sleep_r <= wd & sgbd_pkg::SLEEP_IMPL; // R2 R3
    end
  end

  for (genvar i = 0; i < sgbd_pkg::PERIPH_W; i++) begin : g_run
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        periph_clk_run[i] <= sgbd_pkg::SLEEP_IMPL[i];
      end else begin
        periph_clk_run[i] <= sgbd_pkg::SLEEP_IMPL[i] &&
                             (!sleep_mode || sleep_r[i]); // R1 R20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Backup domain: untouched by the system reset.
  always_ff @(posedge aclk) begin
    if (!bkp_rst_n) begin
      backup_domain_soft_reset_r <= 1'b0; // R5
    end else if (wr_bdc) begin
      backup_domain_soft_reset_r <= wd[sgbd_pkg::BD_BACKUP_DOMAIN_SOFT_RESET];
    end
  end

  always_ff @(posedge aclk) begin
    if (!bkp_rst_n || backup_domain_soft_reset_r) begin
      slow_ext_osc_enable_r  <= 1'b0; // R5 R6
      slow_ext_osc_bypass_r <= 1'b0;
      rtc_source_select_r <= sgbd_pkg::RTC_NONE;
      rtc_clock_gate_r  <= 1'b0;
    end else if (wr_bdc && backup_write_unlock) begin // R4
      slow_ext_osc_enable_r <= wd[sgbd_pkg::BD_SLOW_EXT_OSC_ENABLE]; // R13
      rtc_clock_gate_r <= wd[sgbd_pkg::BD_RTC_CLOCK_GATE];
      if (!slow_ext_osc_enable_r) begin
        slow_ext_osc_bypass_r <= wd[sgbd_pkg::BD_SLOW_EXT_OSC_BYPASS]; // R10
      end
      if (rtc_source_select_r == sgbd_pkg::RTC_NONE) begin
        rtc_source_select_r <= wd[sgbd_pkg::BD_SEL_LO +: 2]; // R9
      end
    end
  end

  // Status register: enable by system reset, flags by power reset only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_int_osc_enable_r <= sgbd_pkg::CSR_RST[sgbd_pkg::CS_SLOW_INT_OSC_ENABLE]; // R15
    end else if (wr_csr) begin
      slow_int_osc_enable_r <= wd[sgbd_pkg::CS_SLOW_INT_OSC_ENABLE];
    end
  end

  // A cause event in the clearing cycle still sets its flag.
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      flags_r <= sgbd_pkg::FLAG_RST; // R15
    end else begin
      flags_r <= (flags_r & ~{sgbd_pkg::FLAG_W{rmv}}) |
                 rst_cause_evt; // R16 R17 R18
    end
  end

  sgbd_osc_ready #(
    .OFF_CYC (sgbd_pkg::LSE_OFF_CYC)
  ) u_lse_rdy (
    .aclk       (aclk),
    .rst_n      (bkp_rst_n && !backup_domain_soft_reset_r),
    .osc_en     (slow_ext_osc_enable_r),
    .osc_stable (slow_ext_osc_stable),
    .osc_clk    (slow_ext_osc_clk),
    .ready      (lse_rdy)
  ); // R11 R12

  sgbd_osc_ready #(
    .OFF_CYC (sgbd_pkg::LSI_OFF_CYC)
  ) u_lsi_rdy (
    .aclk       (aclk),
    .rst_n      (aresetn),
    .osc_en     (slow_int_osc_enable_r),
    .osc_stable (slow_int_osc_stable),
    .osc_clk    (slow_int_osc_clk),
    .ready      (lsi_rdy)
  ); // R19

  always_comb begin
    unique case (rtc_source_select_r)
      sgbd_pkg::RTC_NONE: rtc_clk = 1'b0; // R8
      sgbd_pkg::RTC_LSE:  rtc_clk = rtc_clock_gate_r && slow_ext_osc_clk; // R7
      sgbd_pkg::RTC_LSI:  rtc_clk = rtc_clock_gate_r && slow_int_osc_clk;
      sgbd_pkg::RTC_HSE:  rtc_clk = rtc_clock_gate_r && fast_ext_div_clk;
    endcase
  end

  assign slow_ext_osc_enable = slow_ext_osc_enable_r; // R13
  assign slow_ext_osc_bypass = slow_ext_osc_bypass_r;
  assign slow_int_osc_enable = slow_int_osc_enable_r;
  assign rtc_source_select   = rtc_source_select_r;
  assign bkp_domain_rst      = backup_domain_soft_reset_r || !bkp_rst_n; // R6

  ////////////////////////////////////////////////////////////////////////
  sleep_gate_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    sleep_mode |=> periph_clk_run ==
    ($past(sleep_r[sgbd_pkg::PERIPH_W-1:0]) &
     sgbd_pkg::SLEEP_IMPL[sgbd_pkg::PERIPH_W-1:0]))
    else $error("peripheral clock in sleep differs from its enable");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_r & ~sgbd_pkg::SLEEP_IMPL) == '0) // R2
    else $error("reserved sleep enable bit set");

  sleep_nowait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wst_r == sgbd_pkg::ST_IDLE && aw_have_r && w_have_r &&
    wsel == sgbd_pkg::SEL_SLEEP |-> ##2 s_axi_bvalid) // R3
    else $error("sleep enable write was delayed");

  bkp_lock_a: assert property (@(posedge aclk) disable iff (!bkp_rst_n)
    wr_bdc && !backup_write_unlock && !backup_domain_soft_reset_r |=>
    $stable(rtc_clock_gate_r) && $stable(slow_ext_osc_enable_r) && $stable(rtc_source_select_r)) // R4
    else $error("locked backup bit changed");

  bkp_keep_a: assert property (@(posedge aclk) disable iff (!bkp_rst_n)
    !aresetn && !backup_domain_soft_reset_r |=> $stable(rtc_source_select_r) && $stable(rtc_clock_gate_r)) // R5
    else $error("system reset touched backup bits");

  soft_reset_a: assert property (@(posedge aclk) disable iff (!bkp_rst_n)
    backup_domain_soft_reset_r |=> !slow_ext_osc_enable_r && !rtc_clock_gate_r && rtc_source_select_r == '0) // R6
    else $error("backup soft reset did not clear domain");

  rtc_gate_a: assert property (@(posedge aclk) // R7
    !rtc_clock_gate_r |-> !rtc_clk)
    else $error("rtc clock passed while gated");

  sel_lock_a: assert property (@(posedge aclk) disable iff (!bkp_rst_n)
    rtc_source_select_r != '0 && !backup_domain_soft_reset_r |=> $stable(rtc_source_select_r)) // R9
    else $error("rtc source changed after selection");

  bypass_lock_a: assert property (@(posedge aclk) disable iff (!bkp_rst_n)
    slow_ext_osc_enable_r && !backup_domain_soft_reset_r |=> $stable(slow_ext_osc_bypass_r)) // R10
    else $error("bypass changed while oscillator on");

  bkp_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wst_r == sgbd_pkg::ST_IDLE && aw_have_r && w_have_r && w_bkp
    |-> ##[2:5] s_axi_bvalid) // R14
    else $error("backup write waited out of range");

  flag_set_a: assert property (@(posedge aclk) disable iff (!por_n)
    rst_cause_evt[sgbd_pkg::FLAG_LPWR] |=>
    flags_r[sgbd_pkg::FLAG_LPWR]) // R16
    else $error("low-power flag not set");

  wwdg_set_a: assert property (@(posedge aclk) disable iff (!por_n)
    rst_cause_evt[sgbd_pkg::FLAG_WWDG] |=>
    flags_r[sgbd_pkg::FLAG_WWDG]) // R17
    else $error("watchdog flag not set");

  flag_clear_a: assert property (@(posedge aclk) disable iff (!por_n)
    rmv && rst_cause_evt == '0 |=> flags_r == '0) // R18
    else $error("removal write left flags set");

  cov_sleep_wr: cover property (@(posedge aclk) wr_sleep);
  cov_bkp_wait: cover property (@(posedge aclk) wcnt_r == WAIT_CYC);
  cov_rtc_run: cover property (@(posedge aclk) rtc_clock_gate_r && rtc_clk);
  cov_rmv: cover property (@(posedge aclk) rmv && flags_r != '0);
endmodule

// ### testbench/tb_sgbd_top.sv
// Purpose: Self-checking bench for sgbd_top over AXI4-Lite.
// Assumes: Default backup wait; slow oscillator clocks stepped by hand.
// Notes:   Expected values follow the register map.
`timescale 1ns/100ps
module tb_sgbd_top;
  logic        aclk = 1'b0;
  logic        aresetn, bkp_rst_n, por_n, sleep_mode, backup_write_unlock;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, rtc_clk, bkp_domain_rst;
  logic        slow_ext_osc_stable, slow_ext_osc_clk, slow_int_osc_stable;
  logic        slow_int_osc_clk, fast_ext_div_clk, slow_ext_osc_enable;
  logic        slow_ext_osc_bypass, slow_int_osc_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rtc_source_select, rsp;
  logic [6:0]  rst_cause_evt;
  logic [18:0] periph_clk_run;
  int          error_cnt = 0, checks_done = 0, cyc = 0;

  sgbd_top i_dut (.*);
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      error_cnt++;
    end
  endtask
  // Handshakes are sampled mid-cycle, where they equal the edge values.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tr, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      rd_v = s_axi_rdata;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end while (tb !== 1'b1);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(rd_v, e);
  endtask
  task automatic osc(input int n);
    repeat (n) begin
      @(posedge aclk) {slow_ext_osc_clk, slow_int_osc_clk} <= 2'h3;
      @(posedge aclk) {slow_ext_osc_clk, slow_int_osc_clk} <= 2'h0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, bkp_rst_n, por_n, sleep_mode, backup_write_unlock} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, slow_ext_osc_stable, slow_ext_osc_clk} = '0;
    {slow_int_osc_stable, slow_int_osc_clk, fast_ext_div_clk} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    rst_cause_evt = '0;
    repeat (8) @(posedge aclk);
    {aresetn, bkp_rst_n, por_n} <= 3'h7;
    rd(8'h64, 32'h0007_7930);
    rd(8'h70, 32'h0);
    rd(8'h74, 32'h0E00_0000);
    $display("test reset done");
    wr(8'h64, 32'hFFFF_FFFF);
    chk({30'h0, rsp}, 32'h0);
    rd(8'h64, 32'h0007_7931);
    xfer(1'b1, 8'h64, 32'h0, 4'h2);
    rd(8'h64, 32'h0007_0031);
    wr(8'h64, 32'h0001_0100);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({13'h0, periph_clk_run}, 32'h0001_0100);
    sleep_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({13'h0, periph_clk_run}, 32'h0007_7931);
    $display("test sleep done");
    wr(8'h70, 32'h0000_8101);
    rd(8'h70, 32'h0);
    backup_write_unlock <= 1'b1;
    slow_ext_osc_stable <= 1'b1;
    wr(8'h70, 32'h0000_8101);
    rd(8'h70, 32'h0000_8103);
    chk({30'h0, rtc_source_select}, 32'h1);
    wr(8'h70, 32'h0000_8205);
    rd(8'h70, 32'h0000_8103);
    aresetn <= 1'b0;
    @(posedge aclk) aresetn <= 1'b1;
    rd(8'h70, 32'h0000_8103);
    wr(8'h70, 32'h0000_8100);
    chk({31'h0, slow_ext_osc_enable}, 32'h0);
    osc(5);
    rd(8'h70, 32'h0000_8102);
    osc(1);
    rd(8'h70, 32'h0000_8100);
    wr(8'h70, 32'h0000_8104);
    rd(8'h70, 32'h0000_8104);
    chk({31'h0, slow_ext_osc_bypass}, 32'h1);
    $display("test slow external done");
    wr(8'h70, 32'h0001_0000);
    chk({31'h0, bkp_domain_rst}, 32'h1);
    rd(8'h70, 32'h0001_0000);
    wr(8'h70, 32'h0);
    wr(8'h70, 32'h0000_0200);
    slow_int_osc_clk <= 1'b1;
    rd(8'h70, 32'h0000_0200);
    chk({31'h0, rtc_clk}, 32'h0);
    wr(8'h70, 32'h0000_8200);
    chk({31'h0, rtc_clk}, 32'h1);
    wr(8'h70, 32'h0001_0000);
    wr(8'h70, 32'h0);
    wr(8'h70, 32'h0000_8300);
    {fast_ext_div_clk, slow_int_osc_clk} <= 2'h2;
    @(negedge aclk);
    chk({30'h0, rtc_source_select}, 32'h3);
    chk({31'h0, rtc_clk}, 32'h1);
    $display("test domain done");
    rst_cause_evt <= 7'h60;
    @(posedge aclk) rst_cause_evt <= 7'h00;
    rd(8'h74, 32'hCE00_0000);
    wr(8'h74, 32'h0);
    rd(8'h74, 32'hCE00_0000);
    wr(8'h74, 32'h0100_0000);
    rd(8'h74, 32'h0);
    slow_int_osc_stable <= 1'b1;
    wr(8'h74, 32'h1);
    chk({31'h0, slow_int_osc_enable}, 32'h1);
    rd(8'h74, 32'h3);
    wr(8'h74, 32'h0);
    osc(2);
    rd(8'h74, 32'h2);
    osc(1);
    rd(8'h74, 32'h0);
    xfer(1'b0, 8'h68, 32'h0, 4'h0);
    chk({30'h0, rsp}, 32'h2);
    chk(rd_v, 32'h0);
    xfer(1'b1, 8'h68, 32'h0, 4'hF);
    chk({30'h0, rsp}, 32'h2);
    $display("test status done");
    test_done();
  end
endmodule
